/* File: sbgi_gateway.sv */
`timescale 1ns/1ps
`default_nettype none

module sbgi_gateway #(
  parameter int NCH = sbgi_pkg::NUM_CH,
  parameter int DW  = sbgi_pkg::DATA_W
) (
  input  wire logic              i_clk_sys,          // system clock
  input  wire logic              i_sys_rst,          // async reset, high
  // axi4-lite slave
  input  wire logic [7:0]        i_s_axi_awaddr,     // write address
  input  wire logic              i_s_axi_awvalid,    // write address valid
  output logic                   o_s_axi_awready,    // write address ready
  input  wire logic [31:0]       i_s_axi_wdata,      // write data
  input  wire logic [3:0]        i_s_axi_wstrb,      // byte enables
  input  wire logic              i_s_axi_wvalid,     // write data valid
  output logic                   o_s_axi_wready,     // write data ready
  output logic [1:0]             o_s_axi_bresp,      // write response
  output logic                   o_s_axi_bvalid,     // write response valid
  input  wire logic              i_s_axi_bready,     // write response ready
  input  wire logic [7:0]        i_s_axi_araddr,     // read address
  input  wire logic              i_s_axi_arvalid,    // read address valid
  output logic                   o_s_axi_arready,    // read address ready
  output logic [31:0]            o_s_axi_rdata,      // read data
  output logic [1:0]             o_s_axi_rresp,      // read response
  output logic                   o_s_axi_rvalid,     // read data valid
  input  wire logic              i_s_axi_rready,     // read data ready
  // ring bus side
  input  wire logic              i_cu_data_ready,    // control unit irq pin
  input  wire logic [NCH*DW-1:0] i_ring_rx_data,     // shared memory words
  input  wire logic              i_ring_cycle,       // ring cycle pin
  output logic [NCH*DW-1:0]      o_ring_tx_data,     // values toward ring
  output logic                   o_ring_tx_valid,    // ring output pulse
  output logic [NCH-1:0]         o_ring_tx_used,     // ring channels in use
  // fieldbus side
  input  wire logic [NCH*DW-1:0] i_fb_rx_data,       // fieldbus input words
  input  wire logic              i_fb_rx_valid,      // fieldbus input pulse
  input  wire logic              i_fb_cycle,         // fieldbus cycle pin
  output logic [NCH*DW-1:0]      o_fb_tx_data,       // values toward fieldbus
  output logic                   o_fb_tx_valid,      // fieldbus output pulse
  output logic [NCH-1:0]         o_fb_tx_used,       // fieldbus channels used
  output logic                   o_warning           // substitution fault
);

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [31:0] ctrl;
  logic [31:0] xform;
  logic [31:0] src_lo;
  logic [31:0] src_hi;
  logic [31:0] limit;
  logic        fault;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [2:0]  pin_s1;
  logic [2:0]  pin_s2;
  logic [2:0]  pin_s3;
  logic [2:0]  pin_stab;

  logic [2*NCH-1:0] ring_types;
  logic [2*NCH-1:0] fb_types;
  logic [4*NCH-1:0] ring_src;
  logic [4*NCH-1:0] fb_src;
  logic [7:0]       ring_cnt;
  logic [7:0]       fb_cnt;
  logic             ring_over;
  logic             fb_over;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ****************************************************************
  // pin synchronisers: a level counts once stages two and three agree
  // ****************************************************************
  wire [2:0] pin_in   = {i_fb_cycle, i_ring_cycle, i_cu_data_ready};
  wire [2:0] pin_agr  = ~(pin_s2 ^ pin_s3);
  wire [2:0] pin_rise = pin_agr & pin_s2 & ~pin_stab;

  // synchroniser chain and filtered level
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_s1   <= 3'h0;
      pin_s2   <= 3'h0;
      pin_s3   <= 3'h0;
      pin_stab <= 3'h0;
    end else begin
      pin_s1   <= pin_in;
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_stab <= (pin_agr & pin_s2) | (~pin_agr & pin_stab);
    end
  end

  wire cu_ready_evt = pin_rise[0];   // ring data in shared memory
  wire ring_tick    = pin_rise[1];
  wire fb_tick      = pin_rise[2];

  // ****************************************************************
  // configuration split per direction
  // ****************************************************************
  wire [63:0] src_all = {src_hi, src_lo};

  // even entries toward ring, odd entries toward fieldbus
  for (genvar g = 0; g < NCH; g++) begin : g_split
    assign ring_types[g*2 +: 2] = xform[g*4 +: 2];
    assign fb_types[g*2 +: 2]   = xform[g*4 + 2 +: 2];
    assign ring_src[g*4 +: 4]   = src_all[g*8 +: 4];
    assign fb_src[g*4 +: 4]     = src_all[g*8 + 4 +: 4];
  end

  wire enable    = ctrl[sbgi_pkg::CTRL_ENABLE_BIT];
  wire abort_all = fault | ring_over | fb_over | ~enable;
  wire [7:0] ring_limit = limit[sbgi_pkg::LIMIT_RING_LSB +: 8];
  wire [7:0] fb_limit   = limit[sbgi_pkg::LIMIT_FB_LSB +: 8];

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  wire aw_take   = i_s_axi_awvalid & ~aw_held;
  wire w_take    = i_s_axi_wvalid & ~w_held;
  wire wr_go     = aw_held & w_held & ~o_s_axi_bvalid;
  wire [7:0] wa  = aw_addr;
  wire wr_ctrl   = wr_go && wa == sbgi_pkg::OFS_CTRL;
  wire wr_xform  = wr_go && wa == sbgi_pkg::OFS_XFORM;
  wire wr_src_lo = wr_go && wa == sbgi_pkg::OFS_SRC_LO;
  wire wr_src_hi = wr_go && wa == sbgi_pkg::OFS_SRC_HI;
  wire wr_limit  = wr_go && wa == sbgi_pkg::OFS_LIMIT;
  wire wr_status = wr_go && wa == sbgi_pkg::OFS_STATUS;
  wire wr_hit    = wr_ctrl | wr_xform | wr_src_lo | wr_src_hi | wr_limit | wr_status;
  wire clr_req   = wr_ctrl & w_strb[0] & w_data[sbgi_pkg::CTRL_CLEAR_BIT];

  assign o_s_axi_awready = ~aw_held;
  assign o_s_axi_wready  = ~w_held;

  // address and data may arrive in either order
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= sbgi_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {i_s_axi_awaddr[7:2], 2'h0};
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (wr_go) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= wr_hit ? sbgi_pkg::RESP_OKAY : sbgi_pkg::RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
      end
    end
  end

  // configuration registers; clear bit is self-clearing
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl   <= sbgi_pkg::RST_CTRL;
      xform  <= sbgi_pkg::RST_XFORM;
      src_lo <= sbgi_pkg::RST_SRC;
      src_hi <= sbgi_pkg::RST_SRC;
      limit  <= sbgi_pkg::RST_LIMIT;
    end else begin
      if (wr_ctrl) begin
        ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_0001;
      end
      if (wr_xform) begin
        xform <= merge(xform, w_data, w_strb);
      end
      if (wr_src_lo) begin
        src_lo <= merge(src_lo, w_data, w_strb);
      end
      if (wr_src_hi) begin
        src_hi <= merge(src_hi, w_data, w_strb);
      end
      if (wr_limit) begin
        limit <= merge(limit, w_data, w_strb) & 32'h0000_FFFF;
      end
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  wire [7:0]  ra = {i_s_axi_araddr[7:2], 2'h0};
  wire [31:0] status_word = {8'h00, fb_cnt, ring_cnt, 5'h00, fb_over, ring_over, fault};
  wire        rd_hit = ra <= sbgi_pkg::OFS_STATUS;
  logic [31:0] rd_word;

  // read mux, unmapped reads as zero
  always_comb begin
    unique case (ra)
      sbgi_pkg::OFS_CTRL:   rd_word = ctrl;
      sbgi_pkg::OFS_XFORM:  rd_word = xform;
      sbgi_pkg::OFS_SRC_LO: rd_word = src_lo;
      sbgi_pkg::OFS_SRC_HI: rd_word = src_hi;
      sbgi_pkg::OFS_LIMIT:  rd_word = limit;
      sbgi_pkg::OFS_STATUS: rd_word = status_word;
      default:              rd_word = 32'h0000_0000;
    endcase
  end

  assign o_s_axi_arready = ~o_s_axi_rvalid;

  // read answer one cycle after the address is taken
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= sbgi_pkg::RESP_OKAY;
    end else if (i_s_axi_arvalid && !o_s_axi_rvalid) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata  <= rd_word;
      o_s_axi_rresp  <= rd_hit ? sbgi_pkg::RESP_OKAY : sbgi_pkg::RESP_SLVERR;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // substitution fault: either direction over its limit
  // ****************************************************************
  wire fault_set = ring_over | fb_over;

  // follows the direction flags; their set wins over a clear
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fault <= 1'b0;
    end else if (fault_set) begin
      fault <= 1'b1;
    end else begin
      fault <= 1'b0;                                         // cleared with the flags
    end
  end

  assign o_warning = fault;

  // ****************************************************************
  // direction engines
  // ****************************************************************
  // toward ring: fieldbus input, ring cycle output
  sbgi_dir_xform #(
    .NCH (NCH),
    .DW  (DW)
  ) u_to_ring (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_in_strobe (i_fb_rx_valid),
    .i_in_data   (i_fb_rx_data),
    .i_out_tick  (ring_tick),
    .i_types     (ring_types),
    .i_src       (ring_src),
    .i_limit     (ring_limit),
    .i_abort     (abort_all),
    .i_clear     (clr_req),
    .o_out_data  (o_ring_tx_data),
    .o_out_valid (o_ring_tx_valid),
    .o_out_used  (o_ring_tx_used),
    .o_sub_count (ring_cnt),
    .o_over      (ring_over)
  );

  // toward fieldbus: ring data ready event, fieldbus cycle output
  sbgi_dir_xform #(
    .NCH (NCH),
    .DW  (DW)
  ) u_to_fb (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_in_strobe (cu_ready_evt),
    .i_in_data   (i_ring_rx_data),
    .i_out_tick  (fb_tick),
    .i_types     (fb_types),
    .i_src       (fb_src),
    .i_limit     (fb_limit),
    .i_abort     (abort_all),
    .i_clear     (clr_req),
    .o_out_data  (o_fb_tx_data),
    .o_out_valid (o_fb_tx_valid),
    .o_out_used  (o_fb_tx_used),
    .o_sub_count (fb_cnt),
    .o_over      (fb_over)
  );

endmodule

`default_nettype wire

/* File: sbgi_pkg.sv */
package sbgi_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int NUM_CH  = 8;
  localparam int DATA_W  = 32;
  localparam int TYPE_W  = 2;
  localparam int SRC_W   = 4;
  localparam int CNT_W   = 8;
  localparam int ADDR_W  = 8;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_XFORM  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SRC_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SRC_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LIMIT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_CLEAR_BIT   = 1;
  localparam int LIMIT_RING_LSB   = 0;
  localparam int LIMIT_FB_LSB     = 8;
  localparam int STAT_FAULT_BIT   = 0;
  localparam int STAT_RING_OV_BIT = 1;
  localparam int STAT_FB_OV_BIT   = 2;
  localparam int STAT_RING_CNT_LSB = 8;
  localparam int STAT_FB_CNT_LSB  = 16;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_XFORM = 32'h0000_0000;
  localparam logic [31:0] RST_SRC   = 32'h0000_0000;
  localparam logic [31:0] RST_LIMIT = 32'h0000_0000;

  // ****************************************************************
  // transformation codes, bus answers, timing
  // ****************************************************************
  localparam logic [TYPE_W-1:0] XF_NONE   = 2'h0;
  localparam logic [TYPE_W-1:0] XF_COPY   = 2'h1;
  localparam logic [TYPE_W-1:0] XF_LINEAR = 2'h2;
  localparam logic [TYPE_W-1:0] XF_SQUARE = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam longint CLK_HZ = 200_000_000;

endpackage

/* File: sbgi_dir_xform.sv */
`timescale 1ns/1ps
`default_nettype none

module sbgi_dir_xform #(
  parameter int NCH = sbgi_pkg::NUM_CH,
  parameter int DW  = sbgi_pkg::DATA_W
) (
  input  wire logic                 i_clk_sys,   // system clock
  input  wire logic                 i_sys_rst,   // async reset, high
  input  wire logic                 i_in_strobe, // new input packet
  input  wire logic [NCH*DW-1:0]    i_in_data,   // input channels
  input  wire logic                 i_out_tick,  // destination cycle
  input  wire logic [2*NCH-1:0]     i_types,     // type per channel
  input  wire logic [4*NCH-1:0]     i_src,       // speed source per channel
  input  wire logic [7:0]           i_limit,     // substitute limit
  input  wire logic                 i_abort,     // stop cyclic output
  input  wire logic                 i_clear,     // clear over flag
  output logic      [NCH*DW-1:0]    o_out_data,  // output channels
  output logic                      o_out_valid, // output pulse
  output logic      [NCH-1:0]       o_out_used,  // channel in use
  output logic      [7:0]           o_sub_count, // consecutive substitutes
  output logic                      o_over       // limit exceeded
);

  typedef enum logic [1:0] {ST_IDLE, ST_CALC} sbgi_dstate_t;

  logic [DW-1:0]     cur  [NCH];
  logic [DW-1:0]     prev [NCH];
  logic [31:0]       now;
  logic [31:0]       t_cur;
  logic [31:0]       t_prev;
  logic [31:0]       dt;
  logic              got_input;
  logic [2:0]        idx;
  sbgi_dstate_t      state;

  // linear extrapolation over the measured input period
  function automatic logic [DW-1:0] lin_x(input logic [DW-1:0] c, input logic [DW-1:0] p,
                                          input logic [31:0] d, input logic [31:0] per);
    logic signed [63:0] dl;
    logic signed [63:0] q;
    dl = 64'($signed(c)) - 64'($signed(p));
    q  = (dl * $signed({32'h0000_0000, d})) / $signed({32'h0000_0000, per});
    lin_x = (per == 32'h0000_0000) ? c : c + q[DW-1:0];
  endfunction

  // quadratic: position advanced by mean speed, speed per second
  function automatic logic [DW-1:0] sq_x(input logic [DW-1:0] c, input logic [DW-1:0] vin,
                                         input logic [DW-1:0] vout, input logic [31:0] d);
    logic signed [63:0] mean;
    logic signed [63:0] q;
    mean = (64'($signed(vin)) + 64'($signed(vout))) >>> 1;
    q    = (mean * $signed({32'h0000_0000, d})) / 64'(sbgi_pkg::CLK_HZ);
    sq_x = c + q[DW-1:0];
  endfunction

  // per-channel selection for the channel in calculation
  wire [1:0]    cur_type = i_types[idx*2 +: 2];
  wire [3:0]    src_num  = i_src[idx*4 +: 4];
  wire          src_ok   = (src_num != 4'h0) && (src_num <= 4'(NCH));
  wire [2:0]    src_idx  = 3'(src_num - 4'h1);
  wire [31:0]   period   = t_cur - t_prev;
  wire [DW-1:0] lin_val  = lin_x(cur[idx], prev[idx], dt, period);
  wire [DW-1:0] part_val = lin_x(cur[src_idx], prev[src_idx], dt, period);
  wire [DW-1:0] sq_val   = sq_x(cur[idx], cur[src_idx], part_val, dt);
  wire          have_in  = got_input | i_in_strobe;
  wire          start    = i_out_tick && !i_abort && !o_over && state == ST_IDLE;
  wire          last_ch  = (idx == 3'(NCH-1));
  logic [DW-1:0] res_val;

  // transformation select
  always_comb begin
    unique case (cur_type)
      sbgi_pkg::XF_NONE:   res_val = '0;
      sbgi_pkg::XF_COPY:   res_val = cur[idx];
      sbgi_pkg::XF_LINEAR: res_val = lin_val;
      sbgi_pkg::XF_SQUARE: res_val = src_ok ? sq_val : cur[idx];
    endcase
  end

  // input capture with one-lsb filter on interpolated channels
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int k = 0; k < NCH; k++) begin
        cur[k]  <= '0;
        prev[k] <= '0;
      end
      t_cur  <= 32'h0000_0000;
      t_prev <= 32'h0000_0000;
    end else if (i_in_strobe) begin
      for (int k = 0; k < NCH; k++) begin
        prev[k] <= cur[k];
        if (i_types[k*2 +: 2] >= sbgi_pkg::XF_LINEAR &&
            (i_in_data[k*DW +: DW] - cur[k] + DW'(1)) <= DW'(2)) begin
          cur[k] <= cur[k];
        end else begin
          cur[k] <= i_in_data[k*DW +: DW];
        end
      end
      t_prev <= t_cur;
      t_cur  <= now;
    end
  end

  // time base, substitution counting and fault detection
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      now         <= 32'h0000_0000;
      got_input   <= 1'b0;
      o_sub_count <= 8'h00;
      o_over      <= 1'b0;
    end else begin
      now <= now + 32'h0000_0001;
      if (i_out_tick) begin
        got_input <= 1'b0;
        if (have_in) begin
          o_sub_count <= 8'h00;
        end else if (o_sub_count == i_limit) begin
          o_over <= 1'b1;
        end else begin
          o_sub_count <= o_sub_count + 8'h01;
        end
      end else if (i_in_strobe) begin
        got_input <= 1'b1;
      end
      if (i_clear && !(i_out_tick && !have_in && o_sub_count == i_limit)) begin
        o_over      <= 1'b0;
        o_sub_count <= 8'h00;
      end
    end
  end

  // one channel per clock after each destination tick taken while idle, not aborted and not over
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state       <= ST_IDLE;
      idx         <= 3'h0;
      dt          <= 32'h0000_0000;
      o_out_data  <= '0;
      o_out_valid <= 1'b0;
      o_out_used  <= '0;
    end else begin
      o_out_valid <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            dt    <= now - t_cur;
            idx   <= 3'h0;
            state <= ST_CALC;
          end
        end
        ST_CALC: begin
          o_out_data[idx*DW +: DW] <= res_val;
          o_out_used[idx]          <= (cur_type != sbgi_pkg::XF_NONE);
          idx                      <= idx + 3'h1;
          if (last_ch) begin
            o_out_valid <= !i_abort;
            state       <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: sbgi_gateway_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module sbgi_gateway_props (
  input wire logic i_clk_sys,       // clk
  input wire logic i_sys_rst,       // rst
  input wire logic i_s_axi_arvalid, // ar
  input wire logic o_s_axi_arready, // ar
  input wire logic o_s_axi_rvalid,  // r
  input wire logic i_s_axi_rready,  // r
  input wire logic o_ring_tx_valid, // ring
  input wire logic o_fb_tx_valid,   // fb
  input wire logic o_warning        // fault
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // bus answers, output pacing, fault muting
  AST_R_NEXT: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("rd late");
  AST_R_DONE: assert property (
    o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid) else $error("rd stuck");
  AST_AR_HOLD: assert property (
    o_s_axi_rvalid |-> !o_s_axi_arready) else $error("rd overlap");
  AST_R_CAUSE: assert property (
    $rose(o_s_axi_rvalid) |-> $past(i_s_axi_arvalid)) else $error("rd unasked");
  AST_RING_GAP: assert property (
    o_ring_tx_valid |=> !o_ring_tx_valid [*8]) else $error("ring pulse");
  AST_FB_GAP: assert property (
    o_fb_tx_valid |=> !o_fb_tx_valid [*8]) else $error("fb pulse");
  AST_MUTE_RING: assert property (
    o_warning |-> !o_ring_tx_valid) else $error("ring sends");
  AST_MUTE_FB: assert property (
    o_warning |-> !o_fb_tx_valid) else $error("fb sends");
  CV_FAULT: cover property (o_warning);
  CV_RING: cover property (o_ring_tx_valid);
  CV_FB: cover property (o_fb_tx_valid);
endmodule
bind sbgi_gateway sbgi_gateway_props u_props (.*);
`default_nettype wire

/* File: sbgi_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// cycle pins and control unit
// ****
module sbgi_partner (
  input  wire logic         i_clk_sys, // clk
  input  wire logic         i_run,     // go
  output var  logic         o_cycle,   // cycle pin
  output var  logic         o_cu_rdy,  // irq
  output var  logic [255:0] o_data     // words
);
  logic [5:0] cnt;
  initial {cnt, o_cycle, o_cu_rdy, o_data} = '0;
  // irq once words are written; words churn while not held
  always @(posedge i_clk_sys) begin
    cnt <= i_run ? cnt + 6'h1 : 6'h0;
    o_cycle <= i_run && cnt < 6'h5;
    o_cu_rdy <= i_run && cnt[5] && cnt < 6'h25;
    o_data <= cnt[5] ? {8{32'h433}} : {64{cnt[3:0]}};
  end
endmodule
`default_nettype wire

/* File: sbgi_gateway_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module sbgi_gateway_tb;
  logic i_clk_sys = '0, i_sys_rst = '1, i_s_axi_bready = '1, i_s_axi_rready = '1;
  logic i_s_axi_awvalid = '0, i_s_axi_wvalid = '0, i_s_axi_arvalid = '0, i_fb_rx_valid = '0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic i_cu_data_ready, i_ring_cycle, o_ring_tx_valid, o_fb_tx_valid, o_warning, run = '0;
  logic [7:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0, o_ring_tx_used, o_fb_tx_used;
  logic [31:0] i_s_axi_wdata = '0, o_s_axi_rdata, rd;
  logic [3:0] i_s_axi_wstrb = 4'hF;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rs;
  logic [255:0] i_fb_rx_data = '0, i_ring_rx_data, o_ring_tx_data, o_fb_tx_data;
  wire logic i_fb_cycle = i_ring_cycle;
  int err_total = 0, check_count = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  sbgi_gateway DUT (.*);
  sbgi_partner u_far (.i_clk_sys, .i_run(run), .o_cycle(i_ring_cycle),
    .o_cu_rdy(i_cu_data_ready), .o_data(i_ring_rx_data));
  task automatic chk(input string s, input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  // one register access, held until taken and answered
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [2:0] pend;
    pend = {w, w, !w};
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} <= {a, a, d};
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid} <= pend;
    while (pend != 3'h0) begin
      @(posedge i_clk_sys);
      pend = pend & ~{o_s_axi_awready, o_s_axi_wready, o_s_axi_arready};
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid} <= pend;
    end
    do @(posedge i_clk_sys); while ((w ? o_s_axi_bvalid : o_s_axi_rvalid) !== '1);
    {rd, rs} = {o_s_axi_rdata, w ? o_s_axi_bresp : o_s_axi_rresp};
  endtask
  task automatic t_regs;
    bus('0, 8'h00, '0);
    chk("ctrl", rd, '0);
    bus('1, 8'h04, 32'hFFFF_FFFF);
    bus('0, 8'h04, '0);
    chk("type", rd, 32'hFFFF_FFFF);
    bus('0, 8'h18, '0);
    chk("resp", {30'h0, rs}, 32'h2);
    bus('1, 8'h18, '0);
    chk("wresp", {30'h0, rs}, 32'h2);
    $display("regs done");
  endtask
  task automatic t_flow;
    bus('1, 8'h04, 32'h5);
    bus('1, 8'h10, 32'h808);
    bus('1, 8'h00, 32'h3);
    {i_fb_rx_data, i_fb_rx_valid, run} <= {{8{32'h1234_5678}}, 2'h3};
    @(posedge i_clk_sys);
    i_fb_rx_valid <= '0;
    repeat (2) do @(posedge i_clk_sys); while (o_fb_tx_valid !== '1);
    chk("ring", o_ring_tx_data[31:0], 32'h1234_5678);
    chk("fb", o_fb_tx_data[31:0], 32'h433);
    chk("used", {16'h0, o_ring_tx_used, o_fb_tx_used}, 32'h101);
    bus('1, 8'h10, 32'h801);
    bus('1, 8'h00, 32'h3);
    for (int n = 0; n < 400 && o_warning !== '1; n++) @(posedge i_clk_sys);
    bus('0, 8'h14, '0);
    chk("stat", rd & 32'h00FF_FF07, 32'h0000_0103);
    $display("flow done");
  endtask
  // linear, filtered and square channels toward ring, inputs 33 clocks apart
  task automatic t_lin;
    bus('1, sbgi_pkg::OFS_XFORM, 32'h0000_3225);
    bus('1, sbgi_pkg::OFS_SRC_LO, 32'h0200_0000);
    bus('1, sbgi_pkg::OFS_LIMIT, 32'h0000_0808);
    bus('1, sbgi_pkg::OFS_CTRL, 32'h0000_0003);
    do @(posedge i_clk_sys); while (i_ring_cycle === '1);
    do @(posedge i_clk_sys); while (i_ring_cycle !== '1);
    {i_fb_rx_data[127:32], i_fb_rx_valid} <= {96'h0000_5000_0000_2000_0100_0000, 1'b1};
    @(posedge i_clk_sys);
    i_fb_rx_valid <= '0;
    repeat (32) @(posedge i_clk_sys);
    {i_fb_rx_data[127:32], i_fb_rx_valid} <= {96'h0000_5000_0000_2001_0110_0000, 1'b1};
    @(posedge i_clk_sys);
    i_fb_rx_valid <= '0;
    do @(posedge i_clk_sys); while (o_ring_tx_valid !== '1);
    // slope over 33 clocks, next output 33 clocks after the last input
    chk("lin", o_ring_tx_data[63:32], 32'h0120_0000);
    chk("filt", o_ring_tx_data[95:64], 32'h0000_2000);
    // mean speed 0x0118_0000 per second times 33 clocks at 200 MHz is 3
    chk("sq", o_ring_tx_data[127:96], 32'h0000_5003);
    chk("idle", o_ring_tx_data[159:128], 32'h0000_0000);
    chk("used4", {24'h0, o_ring_tx_used}, 32'h0000_000F);
    $display("lin done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_sys_rst <= '0;
    t_regs;
    t_flow;
    t_lin;
    close_out;
  end
  // watchdog
  initial begin
    #50us;
    err_total++;
    close_out;
  end
endmodule
`default_nettype wire
